// [hdl/devctl_pkg.sv]
// Types shared by the device control register block
// Assumes the constants header is included where offsets are needed
package devctl_pkg;

    // Kind of error message handed to the message path
    typedef enum logic [1:0] {
        MSG_CORR,
        MSG_NONFATAL,
        MSG_FATAL
    } err_msg_e;

    // Three-bit size code, 128 bytes times two to the code
    typedef logic [2:0] size_code_t;

    // Byte count wide enough for 4096
    typedef logic [12:0] byte_count_t;

endpackage

// [hdl/devctl_regs.svh]
// Offsets, field positions, reset values and masks of the device control word
// Assumes byte addressing of configuration space and 16-bit word access
`ifndef DEVCTL_REGS_SVH
`define DEVCTL_REGS_SVH

`define DEVCTL_ADDR          8'h98
`define DEVSTAT_ADDR         8'h9a
`define DEVCTL_RESET         16'h2000
`define DEVSTAT_RESET        16'h0000
`define DEVCTL_RW_MASK       16'h70ef
`define DEVSTAT_W1C_MASK     16'h000f

`define RD_REQ_SIZE_MSB      14
`define RD_REQ_SIZE_LSB      12
`define NO_SNOOP_BIT         11
`define AUX_POWER_PM_BIT     10
`define PHANTOM_FUNC_BIT     9
`define EXT_TAG_BIT          8
`define PAYLOAD_SIZE_MSB     7
`define PAYLOAD_SIZE_LSB     5
`define RELAXED_ORDER_BIT    4
`define UR_REPORT_BIT        3
`define FATAL_REPORT_BIT     2
`define NONFATAL_REPORT_BIT  1
`define CORR_REPORT_BIT      0

`define STAT_UR_BIT          3
`define STAT_FATAL_BIT       2
`define STAT_NONFATAL_BIT    1
`define STAT_CORR_BIT        0

`define SIZE_CODE_MAX        3'h5
`define SIZE_BASE_SHIFT      7

`define RD_REQ_BYTES_RESET   13'h0200
`define PAYLOAD_BYTES_RESET  13'h0080
`define FETCH_BYTES_RESET    13'h0200

`endif

// [hdl/device_control.sv]
// Device control word at 98h with its status word at 9Ah and error messaging
// Assumes configuration accesses and error events arrive on clk_sys
//
// Contract
// - Word at 98h, resets to 2000h
// - Bit 15 reads zero
// - Read request size code at 14:12
// - Reads never exceed limit, sized with cache line
// - No-snoop enable bit reads zero
// - Aux power enable bit reads zero
// - Phantom function enable bit reads zero
// - Extended tag enable bit reads zero
// - Payload size code at 7:5 limits writes
// - Relaxed ordering enable bit reads zero
// - Unsupported request sends nonfatal when enabled
// - Fatal event sends fatal when enabled
// - Nonfatal event sends nonfatal when enabled
// - Correctable event sends correctable when enabled
// - Status flags record errors regardless of enables
`timescale 1ns/1ps
`include "devctl_regs.svh"

module device_control
(
    input  wire logic        clk_sys,             // System clock, 40 MHz
    input  wire logic        rstn,                // Synchronous reset, active low
    input  wire logic [7:0]  cfg_addr,            // Config byte address
    input  wire logic        cfg_wr,              // Config write strobe
    input  wire logic        cfg_rd,              // Config read strobe
    input  wire logic [1:0]  cfg_be,              // Byte enables of the word
    input  wire logic [15:0] cfg_wdata,           // Config write data
    output logic [15:0]      cfg_rdata_q,         // Config read data
    output logic             cfg_rvalid_q,        // Read data valid pulse
    input  wire logic [7:0]  cache_line_dw,       // Cache line size in dwords
    input  wire logic        corr_err_evt,        // Correctable error pulse
    input  wire logic        nonfatal_err_evt,    // Nonfatal error pulse
    input  wire logic        fatal_err_evt,       // Fatal error pulse
    input  wire logic        unsup_req_evt,       // Unsupported request pulse
    output logic             msg_valid_q,         // Error message request
    output devctl_pkg::err_msg_e msg_kind_q,      // Error message kind
    input  wire logic        msg_ready,           // Message path takes message
    output logic [3:0]       err_detected_q,      // Ur, fatal, nonfatal, corr flags
    output logic [2:0]       read_request_size_limit,     // Read size code
    output logic [2:0]       payload_size_limit,          // Payload size code
    output logic             unsupported_request_report_enable, // Ur report enable
    output logic             fatal_error_report_enable,   // Fatal report enable
    output logic             nonfatal_error_report_enable, // Nonfatal report enable
    output logic             correctable_error_report_enable, // Corr report enable
    output logic [12:0]      rd_req_bytes_q,      // Read request limit, bytes
    output logic [12:0]      payload_bytes_q,     // Payload limit, bytes
    output logic [12:0]      fetch_bytes_q        // Bytes per read fetch
);

    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic [15:0] wmask;
    logic        ctl_hit;
    logic        stat_hit;
    logic [15:0] rdata_d;
    logic        rvalid_d;
    logic [3:0]  stat_clr;
    logic [3:0]  evt_vec;
    logic [2:0]  pend_q;
    logic [2:0]  pend_d;
    logic        msg_valid_d;
    devctl_pkg::err_msg_e msg_kind_d;
    logic [3:0]  flags;

    // Lane mask from byte enables
    function automatic logic [15:0] lane_mask(input logic [1:0] be);
        return {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Address decode
    always_comb
    begin
        ctl_hit  = (cfg_addr == `DEVCTL_ADDR);
        stat_hit = (cfg_addr == `DEVSTAT_ADDR);
        wmask    = lane_mask(cfg_be) & `DEVCTL_RW_MASK;
    end

    // Control word next value; read-only bits stay zero
    always_comb
    begin
        ctl_d = ctl_q;
        if (cfg_wr && ctl_hit)
        begin
            ctl_d = (ctl_q & ~wmask) | (cfg_wdata & wmask);
        end
        ctl_d = ctl_d & `DEVCTL_RW_MASK;
    end

    // Control word register
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            ctl_q <= `DEVCTL_RESET;
        end
        else
        begin
            ctl_q <= ctl_d;
        end
    end

    // Field outputs straight from the control flops
    always_comb
    begin
        read_request_size_limit           = ctl_q[`RD_REQ_SIZE_MSB:`RD_REQ_SIZE_LSB];
        payload_size_limit                = ctl_q[`PAYLOAD_SIZE_MSB:`PAYLOAD_SIZE_LSB];
        unsupported_request_report_enable = ctl_q[`UR_REPORT_BIT];
        fatal_error_report_enable         = ctl_q[`FATAL_REPORT_BIT];
        nonfatal_error_report_enable      = ctl_q[`NONFATAL_REPORT_BIT];
        correctable_error_report_enable   = ctl_q[`CORR_REPORT_BIT];
    end

    // Write-one-clear strobes for the status flags
    always_comb
    begin
        stat_clr = 4'h0;
        if (cfg_wr && stat_hit && cfg_be[0])
        begin
            stat_clr = cfg_wdata[3:0] & 4'(`DEVSTAT_W1C_MASK);
        end
        evt_vec = {unsup_req_evt, fatal_err_evt, nonfatal_err_evt, corr_err_evt};
    end

    // Detected flags, independent of the enables
    err_status_flags u_flags
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .evt     (evt_vec),
        .clr     (stat_clr),
        .flags_q (flags)
    );

    // Byte limits and fetch sizing
    size_limit_decode u_sizes
    (
        .clk_sys         (clk_sys),
        .rstn            (rstn),
        .rd_req_code     (ctl_q[`RD_REQ_SIZE_MSB:`RD_REQ_SIZE_LSB]),
        .payload_code    (ctl_q[`PAYLOAD_SIZE_MSB:`PAYLOAD_SIZE_LSB]),
        .cache_line_dw   (cache_line_dw),
        .rd_req_bytes_q  (rd_req_bytes_q),
        .payload_bytes_q (payload_bytes_q),
        .fetch_bytes_q   (fetch_bytes_q)
    );

    // Read data, unmapped offsets read zero
    always_comb
    begin
        rvalid_d = cfg_rd;
        rdata_d  = 16'h0000;
        if (cfg_rd && ctl_hit)
        begin
            rdata_d = ctl_q & lane_mask(cfg_be);
        end
        else if (cfg_rd && stat_hit)
        begin
            rdata_d = {12'h000, flags} & lane_mask(cfg_be);
        end
    end

    // Read answer registers
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cfg_rdata_q  <= 16'h0000;
            cfg_rvalid_q <= 1'b0;
        end
        else
        begin
            cfg_rdata_q  <= rdata_d;
            cfg_rvalid_q <= rvalid_d;
        end
    end

    // Pending messages: bit 2 fatal, 1 nonfatal, 0 correctable
    always_comb
    begin
        pend_d      = pend_q;
        msg_valid_d = msg_valid_q;
        msg_kind_d  = msg_kind_q;
        if (msg_valid_q && msg_ready)
        begin
            msg_valid_d = 1'b0;
        end
        // Highest severity goes first when the slot is free
        if (!msg_valid_d)
        begin
            if (pend_q[2])
            begin
                msg_valid_d = 1'b1;
                msg_kind_d  = devctl_pkg::MSG_FATAL;
                pend_d[2]   = 1'b0;
            end
            else if (pend_q[1])
            begin
                msg_valid_d = 1'b1;
                msg_kind_d  = devctl_pkg::MSG_NONFATAL;
                pend_d[1]   = 1'b0;
            end
            else if (pend_q[0])
            begin
                msg_valid_d = 1'b1;
                msg_kind_d  = devctl_pkg::MSG_CORR;
                pend_d[0]   = 1'b0;
            end
        end
        // New events set pending only when enabled; set beats launch
        if (fatal_err_evt && ctl_q[`FATAL_REPORT_BIT])
        begin
            pend_d[2] = 1'b1;
        end
        if (nonfatal_err_evt && ctl_q[`NONFATAL_REPORT_BIT])
        begin
            pend_d[1] = 1'b1;
        end
        if (unsup_req_evt && ctl_q[`UR_REPORT_BIT])
        begin
            pend_d[1] = 1'b1;
        end
        if (corr_err_evt && ctl_q[`CORR_REPORT_BIT])
        begin
            pend_d[0] = 1'b1;
        end
    end

    // Message registers
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            pend_q      <= 3'h0;
            msg_valid_q <= 1'b0;
            msg_kind_q  <= devctl_pkg::MSG_CORR;
        end
        else
        begin
            pend_q      <= pend_d;
            msg_valid_q <= msg_valid_d;
            msg_kind_q  <= msg_kind_d;
        end
    end

    // Status flags out
    always_comb
    begin
        err_detected_q = flags;
    end

endmodule

// [hdl/err_status_flags.sv]
// Sticky error-detected flags with write-one-to-clear
// Assumes event pulses come from logic on the same clock
`timescale 1ns/1ps
`include "devctl_regs.svh"

module err_status_flags
(
    input  wire logic        clk_sys,      // System clock
    input  wire logic        rstn,         // Synchronous reset, active low
    input  wire logic [3:0]  evt,          // Events: ur, fatal, nonfatal, corr
    input  wire logic [3:0]  clr,          // Write-one-clear strobes
    output logic [3:0]       flags_q       // Sticky detected flags
);

    logic [3:0] flags_d;

    // Each flag sets regardless of enables; set beats clear
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_flag
            always_comb
            begin
                flags_d[i] = (flags_q[i] & ~clr[i]) | evt[i];
            end
        end
    endgenerate

    // Register the flags
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            flags_q <= 4'h0;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

endmodule

// [hdl/size_limit_decode.sv]
// Turns the two size codes into byte limits and sizes read fetches
// Assumes codes come from registers on the same clock
`timescale 1ns/1ps
`include "devctl_regs.svh"

module size_limit_decode
(
    input  wire logic                  clk_sys,          // System clock
    input  wire logic                  rstn,             // Synchronous reset, active low
    input  wire devctl_pkg::size_code_t rd_req_code,     // Read request size code
    input  wire devctl_pkg::size_code_t payload_code,    // Payload size code
    input  wire logic [7:0]            cache_line_dw,    // Cache line size in dwords
    output logic [12:0]                rd_req_bytes_q,   // Read request limit in bytes
    output logic [12:0]                payload_bytes_q,  // Payload limit in bytes
    output logic [12:0]                fetch_bytes_q     // Bytes per read fetch
);

    logic [12:0] rd_req_bytes_d;
    logic [12:0] payload_bytes_d;
    logic [12:0] fetch_bytes_d;
    logic [12:0] line_bytes;

    // Reserved codes fall back to the smallest size
    function automatic logic [12:0] code_to_bytes(input devctl_pkg::size_code_t code);
        logic [12:0] b;
        b = 13'h0080;
        if (code <= `SIZE_CODE_MAX)
        begin
            b = 13'h0001 << (`SIZE_BASE_SHIFT + code);
        end
        return b;
    endfunction

    // Limits and fetch size, never above the read limit
    always_comb
    begin
        rd_req_bytes_d  = code_to_bytes(rd_req_code);
        payload_bytes_d = code_to_bytes(payload_code);
        line_bytes      = {3'h0, cache_line_dw, 2'h0};
        fetch_bytes_d   = rd_req_bytes_d;
        if ((line_bytes != 13'h0000) && (line_bytes < rd_req_bytes_d))
        begin
            fetch_bytes_d = line_bytes;
        end
    end

    // Register the limits
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            rd_req_bytes_q  <= `RD_REQ_BYTES_RESET;
            payload_bytes_q <= `PAYLOAD_BYTES_RESET;
            fetch_bytes_q   <= `FETCH_BYTES_RESET;
        end
        else
        begin
            rd_req_bytes_q  <= rd_req_bytes_d;
            payload_bytes_q <= payload_bytes_d;
            fetch_bytes_q   <= fetch_bytes_d;
        end
    end

endmodule

// [verif/device_control_sva.sv]
// Checker for the control word, error messages and byte limits
// Assumes a bind onto device_control, one clock, synchronous reset
`timescale 1ns/1ps

module device_control_sva
(
    input wire logic                 clk_sys,                         // Clock
    input wire logic                 rstn,                            // Reset
    input wire logic [7:0]           cfg_addr,                        // Address
    input wire logic                 cfg_rd,                          // Read
    input wire logic [15:0]          cfg_rdata_q,                     // Read data
    input wire logic                 cfg_rvalid_q,                    // Read valid
    input wire logic                 corr_err_evt,                    // Corr event
    input wire logic                 nonfatal_err_evt,                // Nonfatal event
    input wire logic                 fatal_err_evt,                   // Fatal event
    input wire logic                 unsup_req_evt,                   // Ur event
    input wire logic                 msg_valid_q,                     // Message
    input wire devctl_pkg::err_msg_e msg_kind_q,                      // Kind
    input wire logic                 msg_ready,                       // Taken
    input wire logic [3:0]           err_detected_q,                  // Flags
    input wire logic [2:0]           read_request_size_limit,         // Read code
    input wire logic                 fatal_error_report_enable,       // Fatal enable
    input wire logic                 correctable_error_report_enable, // Corr enable
    input wire logic [12:0]          rd_req_bytes_q,                  // Read limit
    input wire logic [12:0]          fetch_bytes_q                    // Fetch size
);
    wire logic [3:0] evts = {unsup_req_evt, fatal_err_evt, nonfatal_err_evt, corr_err_evt};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // Steps of a control read and of a message launch
    sequence ctl_read;
        cfg_rd && cfg_addr == 8'h98;
    endsequence
    sequence fatal_sent;
        msg_valid_q && msg_kind_q == devctl_pkg::MSG_FATAL;
    endsequence
    sequence corr_sent;
        msg_valid_q && msg_kind_q == devctl_pkg::MSG_CORR;
    endsequence

    rsvd_read_a: assert property (ctl_read |=> (cfg_rdata_q & 16'h8f10) == 16'h0000)
        else $error("read-only bits of control word read nonzero");
    read_valid_a: assert property (cfg_rd |=> cfg_rvalid_q)
        else $error("read data valid missing");
    fatal_msg_a: assert property (fatal_err_evt && fatal_error_report_enable |-> ##[2:40] fatal_sent)
        else $error("fatal message not sent");
    corr_msg_a: assert property (corr_err_evt && correctable_error_report_enable |-> ##[2:80] corr_sent)
        else $error("correctable message not sent");
    flag_record_a: assert property (|evts |=> (err_detected_q & $past(evts)) == $past(evts))
        else $error("error flag not recorded");
    msg_hold_a: assert property (msg_valid_q && !msg_ready |=> msg_valid_q && $stable(msg_kind_q))
        else $error("message dropped before acceptance");
    read_size_a: assert property (read_request_size_limit <= 3'h5 |=>
        rd_req_bytes_q == (13'h0080 << $past(read_request_size_limit)))
        else $error("read limit bytes wrong");
    fetch_cap_a: assert property (fetch_bytes_q <= rd_req_bytes_q)
        else $error("fetch above read limit");
endmodule

bind device_control device_control_sva u_device_control_sva (.clk_sys, .rstn, .cfg_addr, .cfg_rd,
    .cfg_rdata_q, .cfg_rvalid_q, .corr_err_evt, .nonfatal_err_evt, .fatal_err_evt, .unsup_req_evt,
    .msg_valid_q, .msg_kind_q, .msg_ready, .err_detected_q, .read_request_size_limit,
    .fatal_error_report_enable, .correctable_error_report_enable, .rd_req_bytes_q, .fetch_bytes_q);

// [verif/err_msg_sink.sv]
// Message path of the root complex side, prompt or stalling
// Assumes messages are offered as a level held until accepted
`timescale 1ns/1ps

module err_msg_sink
(
    input  wire logic                 clk_sys,     // Clock
    input  wire logic                 rstn,        // Reset
    input  wire logic                 msg_valid_q, // Message offered
    input  wire devctl_pkg::err_msg_e msg_kind_q,  // Kind offered
    input  wire logic                 slow,        // Stall three cycles
    output logic                      msg_ready,   // Accept
    output logic [7:0]                taken_q,     // Messages taken
    output devctl_pkg::err_msg_e      kind_q       // Last kind taken
);
    logic [1:0] wait_q;
    logic [1:0] wait_d;

    // Accept at once, or after the stall count runs out
    assign msg_ready = msg_valid_q && (!slow || wait_q == 2'h3);

    // Stall count
    always_comb
    begin
        wait_d = (msg_valid_q && !msg_ready) ? wait_q + 2'h1 : 2'h0;
    end

    // Count and log of accepted messages
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            wait_q <= 2'h0;
            taken_q <= 8'h00;
            kind_q <= devctl_pkg::MSG_CORR;
        end
        else
        begin
            wait_q <= wait_d;
            if (msg_ready)
            begin
                taken_q <= taken_q + 8'h01;
                kind_q <= msg_kind_q;
            end
        end
    end
endmodule

// [verif/test_device_control.sv]
// Self-checking bench of the device control word
// Assumes err_msg_sink stands at the message path
`timescale 1ns/1ps

module test_device_control;
    typedef struct packed {
        logic [15:0] wdata;
        logic [1:0]  be;
        logic [15:0] ctl;
        logic [12:0] rd_b;
        logic [12:0] pl_b;
    } row_s;

    // Writes beside the word and byte limits they leave
    row_s rows [8] = '{
        '{16'h8f30, 2'h3, 16'h0020, 13'h0080, 13'h0100},
        '{16'h9f51, 2'h3, 16'h1041, 13'h0100, 13'h0200},
        '{16'haf72, 2'h3, 16'h2062, 13'h0200, 13'h0400},
        '{16'hbf94, 2'h3, 16'h3084, 13'h0400, 13'h0800},
        '{16'hcfb8, 2'h3, 16'h40a8, 13'h0800, 13'h1000},
        '{16'hdf1f, 2'h3, 16'h500f, 13'h1000, 13'h0080},
        '{16'h0000, 2'h1, 16'h5000, 13'h1000, 13'h0080},
        '{16'h0000, 2'h2, 16'h0000, 13'h0080, 13'h0080}};
    devctl_pkg::err_msg_e kinds [4] = '{devctl_pkg::MSG_CORR, devctl_pkg::MSG_NONFATAL,
        devctl_pkg::MSG_FATAL, devctl_pkg::MSG_NONFATAL};

    logic                 clk_sys = 1'b0;
    logic                 rstn = 1'b0;
    logic                 cfg_wr = 1'b0;
    logic                 cfg_rd = 1'b0;
    logic                 slow = 1'b0;
    logic [7:0]           cfg_addr = 8'h00;
    logic [1:0]           cfg_be = 2'h3;
    logic [15:0]          cfg_wdata = 16'h0000;
    logic [7:0]           cache_line_dw = 8'h00;
    logic [3:0]           evt = 4'h0;
    logic [15:0]          cfg_rdata_q;
    logic                 cfg_rvalid_q;
    logic                 msg_valid_q;
    logic                 msg_ready;
    devctl_pkg::err_msg_e msg_kind_q;
    devctl_pkg::err_msg_e kind_q;
    logic [3:0]           err_detected_q;
    logic [12:0]          rd_req_bytes_q;
    logic [12:0]          payload_bytes_q;
    logic [12:0]          fetch_bytes_q;
    logic [7:0]           taken_q;
    logic [7:0]           t0;
    logic [2:0]           rd_code;
    logic [2:0]           pl_code;
    logic [3:0]           rpt_en;
    int                   fail_count = 0;
    int                   check_count = 0;
    int                   cycles = 0;

    device_control u_device_control (.clk_sys(clk_sys), .rstn(rstn), .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .cache_line_dw(cache_line_dw),
        .corr_err_evt(evt[0]), .nonfatal_err_evt(evt[1]), .fatal_err_evt(evt[2]),
        .unsup_req_evt(evt[3]), .msg_valid_q(msg_valid_q), .msg_kind_q(msg_kind_q),
        .msg_ready(msg_ready), .err_detected_q(err_detected_q), .read_request_size_limit(rd_code),
        .payload_size_limit(pl_code), .unsupported_request_report_enable(rpt_en[3]),
        .fatal_error_report_enable(rpt_en[2]), .nonfatal_error_report_enable(rpt_en[1]),
        .correctable_error_report_enable(rpt_en[0]),
        .rd_req_bytes_q(rd_req_bytes_q), .payload_bytes_q(payload_bytes_q), .fetch_bytes_q(fetch_bytes_q));

    err_msg_sink u_err_msg_sink (.clk_sys(clk_sys), .rstn(rstn), .msg_valid_q(msg_valid_q),
        .msg_kind_q(msg_kind_q), .slow(slow), .msg_ready(msg_ready), .taken_q(taken_q), .kind_q(kind_q));

    // Clock of 25 ns
    always #12.5 clk_sys = ~clk_sys;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_kind(input devctl_pkg::err_msg_e exp, input devctl_pkg::err_msg_e got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected message kind: expected %0d seen %0d", exp, got);
        end
    endtask

    task automatic cfg_write(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        @(posedge clk_sys);
        cfg_addr <= a;
        cfg_be <= b;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_sys);
        cfg_addr <= a;
        cfg_be <= 2'h3;
        cfg_rd <= 1'b1;
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
        #1;
        check_word(what, exp, cfg_rdata_q);
    endtask

    task automatic limits(input logic [12:0] rd_b, input logic [12:0] pl_b, input logic [12:0] f_b);
        check_word("read limit", {3'h0, rd_b}, {3'h0, rd_req_bytes_q});
        check_word("payload limit", {3'h0, pl_b}, {3'h0, payload_bytes_q});
        check_word("fetch size", {3'h0, f_b}, {3'h0, fetch_bytes_q});
    endtask

    // Pulse events, then wait a bounded time for a message
    task automatic fire(input logic [3:0] e);
        t0 = taken_q;
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= 4'h0;
        for (int n = 0; n < 30 && taken_q == t0; n++)
            @(posedge clk_sys);
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        read_check(8'h98, 16'h2000, "control reset");
        read_check(8'h9a, 16'h0000, "status reset");
        limits(13'h0200, 13'h0080, 13'h0200);
        cfg_write(8'h9c, 2'h3, 16'hffff);
        read_check(8'h9c, 16'h0000, "unmapped word");
        read_check(8'h98, 16'h2000, "control after stray");
        foreach (rows[i])
        begin
            cfg_write(8'h98, rows[i].be, rows[i].wdata);
            read_check(8'h98, rows[i].ctl, "control word");
            check_word("field outputs", rows[i].ctl, {1'b0, rd_code, 4'h0, pl_code, 1'b0, rpt_en});
            limits(rows[i].rd_b, rows[i].pl_b, rows[i].rd_b);
        end
        // Fetch sized by a cache line below the read limit
        cfg_write(8'h98, 2'h3, 16'h500f);
        cache_line_dw <= 8'h10;
        repeat (3) @(posedge clk_sys);
        limits(13'h1000, 13'h0080, 13'h0040);
        // One message for each event, second and fourth stalled
        for (int i = 0; i < 4; i++)
        begin
            slow <= i[0];
            fire(4'h1 << i);
            check_word("messages taken", {8'h00, t0 + 8'h01}, {8'h00, taken_q});
            check_kind(kinds[i], kind_q);
        end
        // Enables off: flags still set, nothing sent
        cfg_write(8'h98, 2'h3, 16'h5000);
        cfg_write(8'h9a, 2'h1, 16'h000f);
        read_check(8'h9a, 16'h0000, "status cleared");
        fire(4'hf);
        check_word("messages taken", {8'h00, t0}, {8'h00, taken_q});
        read_check(8'h9a, 16'h000f, "status flags");
        // Reset in mid-run brings back the defaults
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        read_check(8'h98, 16'h2000, "control after reset");
        read_check(8'h9a, 16'h0000, "status after reset");
        limits(13'h0200, 13'h0080, 13'h0040);
        print_verdict();
    end
endmodule
